// ==== logic/hsdp_consts.vh ====
`ifndef HSDP_CONSTS_VH
`define HSDP_CONSTS_VH

// Register indices used by the command decoder
`define HSDP_IDX_CONFIG 4'h0
`define HSDP_IDX_GAIN 4'h1
`define HSDP_IDX_OFFSET 4'h2
`define HSDP_IDX_LOW 4'h3
`define HSDP_IDX_HIGH 4'h4
`define HSDP_IDX_TC 4'h5
`define HSDP_IDX_QUADRATIC_TEMP_COEFF 4'h6
`define HSDP_IDX_LOCK 4'h7
`define HSDP_IDX_SAMPLE 4'h8
`define HSDP_IDX_TRIM 4'h9

// Reset values
`define HSDP_RST_CONFIG 6'h10
`define HSDP_RST_GAIN 14'h0800
`define HSDP_RST_OFFSET 11'h000
`define HSDP_RST_LOW 10'h000
`define HSDP_RST_HIGH 11'h400
`define HSDP_RST_TC 10'h000
`define HSDP_RST_QUADRATIC_TEMP_COEFF 8'h00
`define HSDP_RST_RANGE 3'h0

// Field positions in the config register
`define HSDP_RANGE_LSB 0
`define HSDP_RANGE_MSB 2
`define HSDP_FILT_LSB 3
`define HSDP_FILT_MSB 5

// Converter range codes
`define HSDP_RANGE_30MT 3'h0
`define HSDP_RANGE_40MT 3'h4
`define HSDP_RANGE_60MT 3'h5
`define HSDP_RANGE_75MT 3'h1
`define HSDP_RANGE_80MT 3'h6
`define HSDP_RANGE_90MT 3'h2
`define HSDP_RANGE_100MT 3'h7
`define HSDP_RANGE_150MT 3'h3

// Filter corner codes
`define HSDP_FILT_80HZ 3'h0
`define HSDP_FILT_160HZ 3'h1
`define HSDP_FILT_500HZ 3'h2
`define HSDP_FILT_1KHZ 3'h3
`define HSDP_FILT_2KHZ 3'h4

// Low-pass shift per corner
`define HSDP_SHIFT_80HZ 4'h7
`define HSDP_SHIFT_160HZ 4'h6
`define HSDP_SHIFT_500HZ 4'h4
`define HSDP_SHIFT_1KHZ 4'h3
`define HSDP_SHIFT_2KHZ 4'h2

// Sample limits per corner, 14-bit two's complement
`define HSDP_MIN_80HZ 14'h3080
`define HSDP_MAX_80HZ 14'h0f7f
`define HSDP_MIN_160HZ 14'h383f
`define HSDP_MAX_160HZ 14'h07c1
`define HSDP_MIN_500HZ 14'h2b54
`define HSDP_MAX_500HZ 14'h14aa
`define HSDP_MIN_1KHZ 14'h35aa
`define HSDP_MAX_1KHZ 14'h0a55
`define HSDP_MIN_2KHZ 14'h3a18
`define HSDP_MAX_2KHZ 14'h05e7

// Signal scale: one supply span is 2048 counts
`define HSDP_SPAN 20'h00800
`define HSDP_NEG_SPAN 20'hff800
`define HSDP_GAIN_SHIFT 11

`endif

// ==== logic/hsdp_lowpass.v ====
`timescale 1ns/100ps
`default_nettype none
`include "hsdp_consts.vh"

module hsdp_lowpass (
  input wire sys_clk,
  input wire rst,
  input wire raw_valid,
  input wire [13:0] raw_sample,
  input wire [2:0] filter_sel,
  output reg smp_valid_q,
  output reg [13:0] smp_q
);

  reg signed [21:0] acc_q;
  reg [3:0] shift;
  reg [13:0] lim_lo;
  reg [13:0] lim_hi;
  wire signed [21:0] x_w = $signed({raw_sample, 8'h00});
  wire signed [22:0] diff_w = x_w - acc_q;
  wire signed [22:0] step_w = diff_w >>> shift;
  wire signed [22:0] acc_sum = acc_q + step_w;
  wire signed [21:0] acc_d = acc_sum[21:0];
  wire signed [13:0] mean_w = acc_d[21:8];

  // Corner and limit pair per filter setting; unused codes act as 2 kHz
  always @* begin
    case (filter_sel)
      `HSDP_FILT_80HZ: begin
        shift = `HSDP_SHIFT_80HZ;
        lim_lo = `HSDP_MIN_80HZ;
        lim_hi = `HSDP_MAX_80HZ;
      end
      `HSDP_FILT_160HZ: begin
        shift = `HSDP_SHIFT_160HZ;
        lim_lo = `HSDP_MIN_160HZ;
        lim_hi = `HSDP_MAX_160HZ;
      end
      `HSDP_FILT_500HZ: begin
        shift = `HSDP_SHIFT_500HZ;
        lim_lo = `HSDP_MIN_500HZ;
        lim_hi = `HSDP_MAX_500HZ;
      end
      `HSDP_FILT_1KHZ: begin
        shift = `HSDP_SHIFT_1KHZ;
        lim_lo = `HSDP_MIN_1KHZ;
        lim_hi = `HSDP_MAX_1KHZ;
      end
      default: begin
        shift = `HSDP_SHIFT_2KHZ;
        lim_lo = `HSDP_MIN_2KHZ;
        lim_hi = `HSDP_MAX_2KHZ;
      end
    endcase
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      acc_q <= 22'h000000;
      smp_valid_q <= 1'b0;
      smp_q <= 14'h0000;
    end else begin
      smp_valid_q <= raw_valid;
      if (raw_valid) begin
        acc_q <= acc_d;
        if (mean_w < $signed(lim_lo))
          smp_q <= lim_lo;
        else if (mean_w > $signed(lim_hi))
          smp_q <= lim_hi;
        else
          smp_q <= mean_w;
      end
    end
  end

endmodule // hsdp_lowpass

`default_nettype wire

// ==== logic/hsdp_scaler.v ====
`timescale 1ns/100ps
`default_nettype none
`include "hsdp_consts.vh"

module hsdp_scaler (
  input wire sys_clk,
  input wire rst,
  input wire in_valid,
  input wire [13:0] sample,
  input wire [13:0] gain,
  input wire [10:0] offset,
  input wire [9:0] tc,
  input wire [7:0] quadratic_temp_coeff,
  input wire [7:0] temp_delta,
  output reg sig_valid_q,
  output reg [19:0] sig_q
);

  wire signed [7:0] dt_w = temp_delta;
  wire signed [23:0] tc_term = $signed(tc) * dt_w;
  wire signed [23:0] dt2_w = dt_w * dt_w;
  wire signed [23:0] sq_term = $signed(quadratic_temp_coeff) * dt2_w;
  wire signed [23:0] corr_w = tc_term + (sq_term >>> 4);
  wire signed [37:0] gcorr_w = $signed(gain) * corr_w;
  wire signed [37:0] geff_full = $signed(gain) + (gcorr_w >>> 16);
  wire signed [15:0] geff_w = geff_full[15:0];
  wire signed [29:0] prod_w = $signed(sample) * geff_w;
  wire signed [29:0] scaled_w = prod_w >>> `HSDP_GAIN_SHIFT;
  wire signed [19:0] off2_w = $signed({offset, 1'b0});
  wire signed [19:0] sum_w = scaled_w[19:0] + off2_w;
  wire signed [19:0] cap_w = offset[10] ? (off2_w + $signed(`HSDP_SPAN)) : $signed(`HSDP_SPAN);

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sig_valid_q <= 1'b0;
      sig_q <= 20'h00000;
    end else begin
      sig_valid_q <= in_valid;
      if (in_valid) begin
        if (sum_w > cap_w)
          sig_q <= cap_w;
        else if (sum_w < $signed(`HSDP_NEG_SPAN))
          sig_q <= `HSDP_NEG_SPAN;
        else
          sig_q <= sum_w;
      end
    end
  end

endmodule // hsdp_scaler

`default_nettype wire

// ==== logic/hsdp_top.v ====
`timescale 1ns/100ps
`default_nettype none
`include "hsdp_consts.vh"

module hsdp_top (
  input wire sys_clk,
  input wire rst,
  input wire raw_valid,
  input wire [13:0] raw_sample,
  input wire [7:0] die_temp_delta,
  input wire cmd_valid,
  input wire cmd_write,
  input wire [3:0] cmd_index,
  input wire [15:0] cmd_wdata,
  input wire exchange_active,
  input wire reply_serial_bit,
  input wire lock_restore,
  input wire [15:0] factory_trim,
  output reg out_pin_q,
  output reg reply_valid_q,
  output reg reply_err_q,
  output reg [15:0] reply_data_q,
  output reg [2:0] adc_range_q,
  output reg lock_store_q,
  output reg locked_q
);

  // One-hot phases of the device after power-up
  localparam [2:0] ST_BOOT = 3'b001;
  localparam [2:0] ST_OPEN = 3'b010;
  localparam [2:0] ST_SEALED = 3'b100;

  reg [2:0] state_q;
  reg [2:0] state_d;

  reg [5:0] range_filter_config_q;
  reg [13:0] gain_q;
  reg [10:0] zero_field_offset_q;
  reg [9:0] low_level_q;
  reg [10:0] high_level_q;
  reg [9:0] linear_temp_coeff_q;
  reg [7:0] quadratic_temp_coeff_q;
  reg [13:0] filtered_field_sample_q;
  reg switch_state_q;
  reg switch_state_d;
  reg out_pin_d;
  reg lock_store_d;
  reg reply_err_d;
  reg [15:0] reply_data_d;

  reg [15:0] rd_data;
  reg rd_err;

  wire smp_valid;
  wire [13:0] smp_value;
  wire sig_valid;
  wire [19:0] sig_value;

  wire cmd_take = cmd_valid & state_q[1];
  wire wr_take = cmd_take & cmd_write;

  wire signed [19:0] sig_s = sig_value;
  wire signed [19:0] high_s = $signed({9'h000, high_level_q});
  wire signed [19:0] low_s = $signed({10'h000, low_level_q});

  hsdp_lowpass u_lowpass (
    .sys_clk(sys_clk),
    .rst(rst),
    .raw_valid(raw_valid),
    .raw_sample(raw_sample),
    .filter_sel(range_filter_config_q[`HSDP_FILT_MSB:`HSDP_FILT_LSB]),
    .smp_valid_q(smp_valid),
    .smp_q(smp_value)
  );

  hsdp_scaler u_scaler (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(smp_valid),
    .sample(smp_value),
    .gain(gain_q),
    .offset(zero_field_offset_q),
    .tc(linear_temp_coeff_q),
    .quadratic_temp_coeff(quadratic_temp_coeff_q),
    .temp_delta(die_temp_delta),
    .sig_valid_q(sig_valid),
    .sig_q(sig_value)
  );

  // Power-up phase: the stored lock is sampled once after reset release
  always @* begin
    case (state_q)
      ST_BOOT: begin
        state_d = lock_restore ? ST_SEALED : ST_OPEN;
      end
      ST_OPEN: begin
        state_d = ST_OPEN;
      end
      ST_SEALED: begin
        state_d = ST_SEALED;
      end
      default: begin
        state_d = ST_BOOT;
      end
    endcase
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_BOOT;
      locked_q <= 1'b0;
    end else begin
      state_q <= state_d;
      locked_q <= state_d[2];
    end
  end

  // Writable parameter registers
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      range_filter_config_q <= `HSDP_RST_CONFIG;
      gain_q <= `HSDP_RST_GAIN;
      zero_field_offset_q <= `HSDP_RST_OFFSET;
      low_level_q <= `HSDP_RST_LOW;
      high_level_q <= `HSDP_RST_HIGH;
      linear_temp_coeff_q <= `HSDP_RST_TC;
      quadratic_temp_coeff_q <= `HSDP_RST_QUADRATIC_TEMP_COEFF;
    end else if (wr_take) begin
      case (cmd_index)
        `HSDP_IDX_CONFIG: begin
          range_filter_config_q <= cmd_wdata[5:0];
        end
        `HSDP_IDX_GAIN: begin
          gain_q <= cmd_wdata[13:0];
        end
        `HSDP_IDX_OFFSET: begin
          zero_field_offset_q <= cmd_wdata[10:0];
        end
        `HSDP_IDX_LOW: begin
          low_level_q <= cmd_wdata[9:0];
        end
        `HSDP_IDX_HIGH: begin
          high_level_q <= cmd_wdata[10:0];
        end
        `HSDP_IDX_TC: begin
          linear_temp_coeff_q <= cmd_wdata[9:0];
        end
        `HSDP_IDX_QUADRATIC_TEMP_COEFF: begin
          quadratic_temp_coeff_q <= cmd_wdata[7:0];
        end
        default: begin
          range_filter_config_q <= range_filter_config_q;
        end
      endcase
    end
  end

  // Lock request next value: only a written one moves it
  always @* begin
    lock_store_d = lock_store_q;
    if (wr_take && cmd_index == `HSDP_IDX_LOCK && cmd_wdata[0]) begin
      lock_store_d = 1'b1;
    end
  end

  // Lock request is sticky and goes to the non-volatile store
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lock_store_q <= 1'b0;
    end else begin
      lock_store_q <= lock_store_d;
    end
  end

  // Converter range drive
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      adc_range_q <= `HSDP_RST_RANGE;
    end else begin
      adc_range_q <= range_filter_config_q[`HSDP_RANGE_MSB:`HSDP_RANGE_LSB];
    end
  end

  // Filtered sample capture
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      filtered_field_sample_q <= 14'h0000;
    end else if (smp_valid) begin
      filtered_field_sample_q <= smp_value;
    end
  end

  // Read multiplexer
  always @* begin
    rd_data = 16'h0000;
    rd_err = 1'b0;
    case (cmd_index)
      `HSDP_IDX_CONFIG: begin
        rd_data = {10'h000, range_filter_config_q};
      end
      `HSDP_IDX_GAIN: begin
        rd_data = {2'h0, gain_q};
      end
      `HSDP_IDX_OFFSET: begin
        rd_data = {5'h00, zero_field_offset_q};
      end
      `HSDP_IDX_LOW: begin
        rd_data = {6'h00, low_level_q};
      end
      `HSDP_IDX_HIGH: begin
        rd_data = {5'h00, high_level_q};
      end
      `HSDP_IDX_TC: begin
        rd_data = {6'h00, linear_temp_coeff_q};
      end
      `HSDP_IDX_QUADRATIC_TEMP_COEFF: begin
        rd_data = {8'h00, quadratic_temp_coeff_q};
      end
      `HSDP_IDX_LOCK: begin
        rd_data = {15'h0000, lock_store_q};
      end
      `HSDP_IDX_SAMPLE: begin
        rd_data = {2'h0, filtered_field_sample_q};
      end
      `HSDP_IDX_TRIM: begin
        rd_data = factory_trim;
      end
      default: begin
        rd_err = 1'b1;
      end
    endcase
  end

  // Reply contents: writes answer with zero data
  always @* begin
    reply_data_d = 16'h0000;
    reply_err_d = rd_err;
    if (cmd_write) begin
      if (cmd_index == `HSDP_IDX_SAMPLE || cmd_index == `HSDP_IDX_TRIM) begin
        reply_err_d = 1'b1;
      end
    end else begin
      reply_data_d = rd_data;
    end
  end

  // Reply to each accepted command one cycle later
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reply_valid_q <= 1'b0;
      reply_err_q <= 1'b0;
      reply_data_q <= 16'h0000;
    end else begin
      reply_valid_q <= cmd_take;
      if (cmd_take) begin
        reply_data_q <= reply_data_d;
        reply_err_q <= reply_err_d;
      end
    end
  end

  // Comparator next state, updated only with a fresh signal
  always @* begin
    switch_state_d = switch_state_q;
    if (sig_valid) begin
      if (sig_s > high_s) begin
        switch_state_d = 1'b0;
      end else if (sig_s < low_s) begin
        switch_state_d = 1'b1;
      end else begin
        switch_state_d = switch_state_q;
      end
    end
  end

  // Comparator with hysteresis
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      switch_state_q <= 1'b1;
    end else begin
      switch_state_q <= switch_state_d;
    end
  end

  // Output pin source: reply line during an exchange in the open phase, switch state otherwise
  always @* begin
    out_pin_d = switch_state_q;
    if (exchange_active && state_q[1]) begin
      out_pin_d = reply_serial_bit;
    end
  end

  // Output pin register
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      out_pin_q <= 1'b1;
    end else begin
      out_pin_q <= out_pin_d;
    end
  end

endmodule // hsdp_top

`default_nettype wire

// ==== verif/hsdp_prog_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module hsdp_prog_model (
  input wire logic sys_clk,
  output logic cmd_valid,
  output logic cmd_write,
  output logic [3:0] cmd_index,
  output logic [15:0] cmd_wdata,
  output logic exchange_active,
  output logic reply_serial_bit
);
  logic slow = 1'b0;
  logic reply_tog = 1'b0;
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_index = 4'h0;
    cmd_wdata = 16'h0000;
    exchange_active = 1'b0;
  end
  // Telegram reply bits change every cycle so a stale pin shows
  always @(negedge sys_clk) reply_tog <= ~reply_tog;
  assign reply_serial_bit = reply_tog;
  // Alternates prompt and slow exchanges; returns at the falling edge half a cycle after the taking edge
  task automatic command(input logic wr, input logic [3:0] ix, input logic [15:0] wd);
    @(negedge sys_clk);
    exchange_active = 1'b1;
    slow = ~slow;
    repeat (slow ? 3 : 0) @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_index = ix;
    cmd_wdata = wd;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    cmd_index = ~ix;
    cmd_wdata = ~wd;
    exchange_active = 1'b0;
  endtask
endmodule // hsdp_prog_model
`default_nettype wire

// ==== verif/hsdp_properties.sv ====
`timescale 1ns/100ps
`default_nettype none
module hsdp_properties (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [3:0] cmd_index,
  input wire logic [15:0] cmd_wdata,
  input wire logic exchange_active,
  input wire logic reply_serial_bit,
  input wire logic [15:0] factory_trim,
  input wire logic out_pin_q,
  input wire logic reply_valid_q,
  input wire logic reply_err_q,
  input wire logic [15:0] reply_data_q,
  input wire logic [2:0] adc_range_q,
  input wire logic lock_store_q,
  input wire logic locked_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_reply_cause: assert property (reply_valid_q |-> $past(cmd_valid))
    else $error("reply without a command");
  a_sealed_quiet: assert property (locked_q |=> !reply_valid_q)
    else $error("sealed device replied");
  a_lock_sticky: assert property (lock_store_q |=> lock_store_q)
    else $error("lock request cleared");
  a_lock_set: assert property (reply_valid_q && $past(cmd_write) && $past(cmd_index) == 4'h7
    && $past(cmd_wdata[0]) |-> lock_store_q)
    else $error("lock write not stored");
  a_ro_refuse: assert property (reply_valid_q && $past(cmd_write)
    && $past(cmd_index[3:1]) == 3'h4 |-> reply_err_q)
    else $error("write to read-only accepted");
  a_unmapped_err: assert property (reply_valid_q && $past(cmd_index) > 4'h9
    |-> reply_err_q && reply_data_q == 16'h0000)
    else $error("unmapped index not flagged");
  a_trim_read: assert property (reply_valid_q && !$past(cmd_write) && $past(cmd_index) == 4'h9
    |-> !reply_err_q && reply_data_q == $past(factory_trim))
    else $error("trim read wrong");
  a_range_out: assert property (reply_valid_q && $past(cmd_write) && $past(cmd_index) == 4'h0
    |=> adc_range_q == $past(cmd_wdata[2:0], 2))
    else $error("range code not driven");
  a_exch_pin: assert property (exchange_active && !locked_q && $past(!rst)
    |=> out_pin_q == $past(reply_serial_bit))
    else $error("pin not carrying reply");
  c_err: cover property (reply_valid_q && reply_err_q);
  c_lock: cover property (lock_store_q);
  c_switch: cover property (!exchange_active ##1 $fell(out_pin_q));
endmodule // hsdp_properties
bind hsdp_top hsdp_properties hsdp_properties_i (.sys_clk(sys_clk), .rst(rst),
  .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_index(cmd_index), .cmd_wdata(cmd_wdata),
  .exchange_active(exchange_active), .reply_serial_bit(reply_serial_bit),
  .factory_trim(factory_trim), .out_pin_q(out_pin_q), .reply_valid_q(reply_valid_q),
  .reply_err_q(reply_err_q), .reply_data_q(reply_data_q), .adc_range_q(adc_range_q),
  .lock_store_q(lock_store_q), .locked_q(locked_q));
`default_nettype wire

// ==== verif/test_hall_switch_dsp_path.sv ====
`timescale 1ns/100ps
`default_nettype none
module test_hall_switch_dsp_path;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic raw_valid = 1'b0;
  logic [13:0] raw_sample = 14'h0000;
  logic lock_restore = 1'b0;
  logic [7:0] die_temp_delta = 8'h00;
  logic cmd_valid, cmd_write, exchange_active, reply_serial_bit;
  logic [3:0] cmd_index;
  logic [15:0] cmd_wdata, reply_data_q;
  logic out_pin_q, reply_valid_q, reply_err_q, lock_store_q, locked_q;
  logic [2:0] adc_range_q;
  int err_total = 0;
  int cmp_count = 0;
  logic [15:0] rst_v [7] = '{16'h0010, 16'h0800, 16'h0000, 16'h0000, 16'h0400, 16'h0, 16'h0};
  logic [15:0] msk_v [7] = '{16'h003f, 16'h3fff, 16'h07ff, 16'h03ff, 16'h07ff, 16'h3ff, 16'hff};
  logic [15:0] set_v [7] = '{16'h0020, 16'h0800, 16'h0000, 16'h0064, 16'h0190, 16'h0, 16'h0};
  always #5 sys_clk = ~sys_clk;
  hsdp_top hsdp_top_i (.sys_clk(sys_clk), .rst(rst), .raw_valid(raw_valid),
    .raw_sample(raw_sample), .die_temp_delta(die_temp_delta), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_index(cmd_index), .cmd_wdata(cmd_wdata),
    .exchange_active(exchange_active), .reply_serial_bit(reply_serial_bit),
    .lock_restore(lock_restore), .factory_trim(16'h5a3c), .out_pin_q(out_pin_q),
    .reply_valid_q(reply_valid_q), .reply_err_q(reply_err_q), .reply_data_q(reply_data_q),
    .adc_range_q(adc_range_q), .lock_store_q(lock_store_q), .locked_q(locked_q));
  hsdp_prog_model hsdp_prog_model_i (.sys_clk(sys_clk), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_index(cmd_index), .cmd_wdata(cmd_wdata),
    .exchange_active(exchange_active), .reply_serial_bit(reply_serial_bit));
  task automatic finish_test;
    if (err_total == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic acc(input logic wr, input logic [3:0] ix, input logic [15:0] wd,
      input logic [15:0] exp, input logic err);
    hsdp_prog_model_i.command(wr, ix, wd);
    chk("reply_valid", {15'h0, reply_valid_q}, 16'h0001);
    chk("reply_data", reply_data_q, exp);
    chk("reply_err", {15'h0, reply_err_q}, {15'h0, err});
  endtask
  task automatic feed(input logic [13:0] x, input logic pin);
    repeat (80) begin
      @(negedge sys_clk);
      raw_valid = 1'b1;
      raw_sample = x;
    end
    @(negedge sys_clk);
    raw_valid = 1'b0;
    repeat (6) @(negedge sys_clk);
    chk("out_pin", {15'h0, out_pin_q}, {15'h0, pin});
  endtask
  task automatic do_reset(input logic lk);
    @(negedge sys_clk);
    rst = 1'b1;
    lock_restore = lk;
    repeat (16) @(negedge sys_clk);
    rst = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask
  initial begin
    #500us;
    err_total++;
    finish_test();
  end
  initial begin
    do_reset(1'b0);
    for (int i = 0; i < 7; i++) begin
      acc(1'b0, i[3:0], 16'h0000, rst_v[i], 1'b0);
      acc(1'b1, i[3:0], 16'hffff, 16'h0000, 1'b0);
      acc(1'b0, i[3:0], 16'h0000, msk_v[i], 1'b0);
    end
    for (int i = 0; i < 8; i++) begin
      acc(1'b1, 4'h0, {10'h0, i[2:0], i[2:0]}, 16'h0000, 1'b0);
      @(negedge sys_clk);
      chk("adc_range", {13'h0, adc_range_q}, {13'h0, i[2:0]});
      acc(1'b0, 4'h0, 16'h0000, {10'h0, i[2:0], i[2:0]}, 1'b0);
    end
    for (int i = 10; i < 16; i++) begin
      acc(i[0], i[3:0], 16'h1234, 16'h0000, 1'b1);
    end
    acc(1'b1, 4'h8, 16'h0001, 16'h0000, 1'b1);
    acc(1'b1, 4'h9, 16'h0001, 16'h0000, 1'b1);
    acc(1'b0, 4'h9, 16'h0000, 16'h5a3c, 1'b0);
    for (int i = 0; i < 7; i++) begin
      acc(1'b1, i[3:0], set_v[i], 16'h0000, 1'b0);
    end
    feed(-14'sd2000, 1'b1);
    acc(1'b0, 4'h8, 16'h0000, 16'h3a18, 1'b0);
    feed(14'd200, 1'b1);
    feed(14'd2000, 1'b0);
    acc(1'b0, 4'h8, 16'h0000, 16'h05e7, 1'b0);
    feed(14'd200, 1'b0);
    feed(-14'sd2000, 1'b1);
    acc(1'b1, 4'h1, 16'h1000, 16'h0000, 1'b0);
    acc(1'b1, 4'h2, 16'h0600, 16'h0000, 1'b0);
    acc(1'b1, 4'h4, 16'h044c, 16'h0000, 1'b0);
    feed(14'd2000, 1'b1);
    acc(1'b1, 4'h4, 16'h03e8, 16'h0000, 1'b0);
    feed(14'd2000, 1'b0);
    acc(1'b1, 4'h1, 16'h0800, 16'h0000, 1'b0);
    acc(1'b1, 4'h2, 16'h0000, 16'h0000, 1'b0);
    acc(1'b1, 4'h3, 16'h03e8, 16'h0000, 1'b0);
    acc(1'b1, 4'h4, 16'h05dc, 16'h0000, 1'b0);
    feed(14'd2000, 1'b0);
    // Linear coefficient -512 at a delta of 64 halves the gain
    acc(1'b1, 4'h5, 16'h0200, 16'h0000, 1'b0);
    die_temp_delta = 8'h40;
    feed(14'd2000, 1'b1);
    acc(1'b1, 4'h7, 16'h0000, 16'h0000, 1'b0);
    acc(1'b0, 4'h7, 16'h0000, 16'h0000, 1'b0);
    acc(1'b1, 4'h7, 16'h0001, 16'h0000, 1'b0);
    chk("lock_store", {15'h0, lock_store_q}, 16'h0001);
    acc(1'b0, 4'h7, 16'h0000, 16'h0001, 1'b0);
    acc(1'b0, 4'h8, 16'h0000, 16'h05e7, 1'b0);
    do_reset(1'b1);
    chk("locked", {15'h0, locked_q}, 16'h0001);
    hsdp_prog_model_i.command(1'b0, 4'h9, 16'h0000);
    chk("reply_valid", {15'h0, reply_valid_q}, 16'h0000);
    chk("out_pin", {15'h0, out_pin_q}, 16'h0001);
    finish_test();
  end
endmodule // test_hall_switch_dsp_path
`default_nettype wire
